/* design/sats_defines.svh */
// Constants of the sensor ADC test port: command codes, widths and timing.
// Assumes the core clock runs at 100 MHz and that nothing else defines these names.
//
// What this block does
// - Device counts as selected only while both select inputs are high.
// - Deselected device floats every digital output and ignores every digital input.
// - The serial data line is used only while the program mode pin is high.
// - While testing, the data line returns the running ROM address and instruction data.
// - After deselect the data line floats until the test system starts a conversion.
// - The serial output carries the running instruction result while programming or testing.
// - The serial output floats whenever the program mode pin is low.
// - The result is a parallel word with bit 11 as its most significant bit.
// - An optional start input lets the system delay conversions for sensor warm-up.
// - In program mode a rising reset edge enables commands; otherwise it is ignored.
// - The data line turns into an output only after command 8 hex or A hex.
// - A strobe pulses at each conversion end while selected; its falling edge may latch the result.
`ifndef SATS_DEFINES_SVH
`define SATS_DEFINES_SVH

`define SATS_CLK_NS 10
`define SATS_CMD_W 4
`define SATS_CMD_CNT_W 3
`define SATS_CMD_ROM_STREAM 4'h8
`define SATS_CMD_ROM_STREAM_ALT 4'ha
`define SATS_RESULT_W 12
`define SATS_RESULT_MSB 11
`define SATS_EOC_NS 50
`define SATS_EOC_CYC ((`SATS_EOC_NS + `SATS_CLK_NS - 1) / `SATS_CLK_NS)
`define SATS_EOC_CNT_W 4

`endif

/* design/sats_pkg.sv */
// Types shared by the sensor ADC test port.
// Assumes sats_defines.svh is compiled alongside.
package sats_pkg;

  // Pin levels taken from outside the core clock domain.
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic prog;
    logic rst;
    logic start;
    logic io;
    logic osc;
  } sats_pins_type;

  // Command receiver states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LISTEN = 3'b010,
    ST_STREAM = 3'b100
  } sats_state_type;

endpackage

/* design/sats_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module sats_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output var logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* design/sats_top.sv */
// Pin-level select logic and serial test port of the sensor ADC.
// Assumes DSP address, instruction, result and conversion data arrive on I_MCLK.
`timescale 1ns/1ns
`default_nettype none
`include "sats_defines.svh"
module sats_top import sats_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int RES_W = 16
) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_MCE,
  input wire logic I_SELECT_IN_A,
  input wire logic I_SELECT_IN_B,
  input wire logic I_PROGRAM_MODE_PIN,
  input wire logic I_RESET_PIN,
  input wire logic I_CONV_START,
  input wire logic I_OSC_IN_PIN,
  input wire logic I_TEST_SERIAL_IO_I,
  input wire logic [ADDR_W-1:0] I_DSP_ROM_ADDR,
  input wire logic [DATA_W-1:0] I_DSP_INSTR_DATA,
  input wire logic [RES_W-1:0] I_DSP_RESULT,
  input wire logic [`SATS_RESULT_W-1:0] I_RESULT,
  input wire logic I_CONV_DONE,
  output var logic O_TEST_SERIAL_IO_O,
  output var logic O_TEST_SERIAL_IO_OE,
  output var logic O_TEST_SERIAL_OUT,
  output var logic O_TEST_SERIAL_OUT_OE,
  output var logic [`SATS_RESULT_W-1:0] O_RESULT,
  output var logic O_RESULT_OE,
  output var logic O_CONV_DONE_STROBE,
  output var logic O_CONV_DONE_OE,
  output var logic O_CONV_START_REQ,
  output var logic O_CMD_VALID,
  output var logic [`SATS_CMD_W-1:0] O_CMD_CODE
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************

  sats_pins_type pins_a;
  sats_pins_type pins_s;
  sats_pins_type pins_q;
  logic [2:0] edge_ok_q;

  assign pins_a = '{sel_a: I_SELECT_IN_A, sel_b: I_SELECT_IN_B, prog: I_PROGRAM_MODE_PIN,
    rst: I_RESET_PIN, start: I_CONV_START, io: I_TEST_SERIAL_IO_I, osc: I_OSC_IN_PIN};

  sats_sync #(.W($bits(sats_pins_type))) u_sync (
    .i_clk(I_MCLK),
    .i_resetn(I_RESETN),
    .i_ce(I_MCE),
    .i_async(pins_a),
    .o_sync(pins_s)
  );

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      pins_q <= '0;
      edge_ok_q <= '0;
    end else if (I_MCE) begin
      pins_q <= pins_s;
      edge_ok_q <= {edge_ok_q[1:0], 1'b1};
    end
  end

  logic sel;
  logic prog;
  logic osc_rise;
  logic osc_fall;
  logic rst_rise;
  logic start_rise;

  assign sel = pins_s.sel_a && pins_s.sel_b;
  assign prog = sel && pins_s.prog;
  assign osc_rise = edge_ok_q[2] && pins_s.osc && !pins_q.osc;
  assign osc_fall = edge_ok_q[2] && !pins_s.osc && pins_q.osc;
  assign rst_rise = edge_ok_q[2] && pins_s.rst && !pins_q.rst;
  assign start_rise = edge_ok_q[2] && sel && pins_s.start && !pins_q.start;

  // ****************************************************************
  // Command receiver
  // ****************************************************************

  sats_state_type state_q;
  logic [`SATS_CMD_W-1:0] cmd_sh_q;
  logic [`SATS_CMD_CNT_W-1:0] cmd_cnt_q;
  logic [`SATS_CMD_W-1:0] cmd_next;
  logic cmd_last;
  logic cmd_stream;

  assign cmd_next = {cmd_sh_q[`SATS_CMD_W-2:0], pins_s.io};
  assign cmd_last = (cmd_cnt_q == `SATS_CMD_CNT_W'(`SATS_CMD_W - 1));
  assign cmd_stream = (cmd_next == `SATS_CMD_ROM_STREAM) ||
    (cmd_next == `SATS_CMD_ROM_STREAM_ALT);

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      state_q <= ST_IDLE;
      cmd_sh_q <= '0;
      cmd_cnt_q <= '0;
      O_CMD_VALID <= 1'b0;
      O_CMD_CODE <= '0;
    end else if (I_MCE) begin
      O_CMD_VALID <= 1'b0;
      if (!prog) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (rst_rise) begin
              state_q <= ST_LISTEN;
              cmd_cnt_q <= '0;
            end
          end
          ST_LISTEN: begin
            if (osc_rise) begin
              cmd_sh_q <= cmd_next;
              cmd_cnt_q <= cmd_last ? '0 : cmd_cnt_q + 1'b1;
              if (cmd_last) begin
                O_CMD_VALID <= 1'b1;
                O_CMD_CODE <= cmd_next;
                if (cmd_stream) begin
                  state_q <= ST_STREAM;
                end
              end
            end
          end
          ST_STREAM: begin
            if (rst_rise) begin
              state_q <= ST_LISTEN;
              cmd_cnt_q <= '0;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Serial data line: float hold and address plus instruction stream
  // ****************************************************************

  localparam int IO_W = ADDR_W + DATA_W;
  logic hold_q;
  logic [IO_W-1:0] io_sh_q;
  logic [$clog2(IO_W+1)-1:0] io_cnt_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      hold_q <= 1'b0;
    end else if (I_MCE) begin
      if (!sel) begin
        hold_q <= 1'b1;
      end else if (start_rise) begin
        hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      io_sh_q <= '0;
      io_cnt_q <= '0;
      O_TEST_SERIAL_IO_O <= 1'b0;
      O_TEST_SERIAL_IO_OE <= 1'b0;
    end else if (I_MCE) begin
      O_TEST_SERIAL_IO_OE <= prog && !hold_q && (state_q == ST_STREAM);
      if (state_q != ST_STREAM) begin
        io_cnt_q <= '0;
      end else if (osc_fall) begin
        if (io_cnt_q == '0) begin
          io_sh_q <= {I_DSP_ROM_ADDR, I_DSP_INSTR_DATA};
          O_TEST_SERIAL_IO_O <= I_DSP_ROM_ADDR[ADDR_W-1];
          io_cnt_q <= ($clog2(IO_W+1))'(IO_W - 1);
        end else begin
          io_sh_q <= {io_sh_q[IO_W-2:0], 1'b0};
          O_TEST_SERIAL_IO_O <= io_sh_q[IO_W-2];
          io_cnt_q <= io_cnt_q - 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Serial result output
  // ****************************************************************

  logic [RES_W-1:0] res_sh_q;
  logic [$clog2(RES_W+1)-1:0] res_cnt_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      res_sh_q <= '0;
      res_cnt_q <= '0;
      O_TEST_SERIAL_OUT <= 1'b0;
      O_TEST_SERIAL_OUT_OE <= 1'b0;
    end else if (I_MCE) begin
      O_TEST_SERIAL_OUT_OE <= prog;
      if (!prog) begin
        res_cnt_q <= '0;
      end else if (osc_fall) begin
        if (res_cnt_q == '0) begin
          res_sh_q <= I_DSP_RESULT;
          O_TEST_SERIAL_OUT <= I_DSP_RESULT[RES_W-1];
          res_cnt_q <= ($clog2(RES_W+1))'(RES_W - 1);
        end else begin
          res_sh_q <= {res_sh_q[RES_W-2:0], 1'b0};
          O_TEST_SERIAL_OUT <= res_sh_q[RES_W-2];
          res_cnt_q <= res_cnt_q - 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Parallel result, end of conversion strobe and conversion start
  // ****************************************************************

  logic [`SATS_EOC_CNT_W-1:0] eoc_cnt_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      O_RESULT <= '0;
      O_RESULT_OE <= 1'b0;
      O_CONV_DONE_OE <= 1'b0;
      O_CONV_DONE_STROBE <= 1'b0;
      O_CONV_START_REQ <= 1'b0;
      eoc_cnt_q <= '0;
    end else if (I_MCE) begin
      O_RESULT_OE <= sel;
      O_CONV_DONE_OE <= sel;
      O_CONV_START_REQ <= sel && pins_s.start;
      if (I_CONV_DONE && sel) begin
        O_RESULT <= I_RESULT;
        O_CONV_DONE_STROBE <= 1'b1;
        eoc_cnt_q <= `SATS_EOC_CNT_W'(`SATS_EOC_CYC - 1);
      end else if (eoc_cnt_q != '0) begin
        eoc_cnt_q <= eoc_cnt_q - 1'b1;
      end else begin
        O_CONV_DONE_STROBE <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence s_deselect;
    sel ##1 !sel;
  endsequence

  sequence s_done;
    I_CONV_DONE && sel;
  endsequence

  chk_select_gate: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    !sel |=> !O_RESULT_OE && !O_TEST_SERIAL_IO_OE && !O_CONV_DONE_OE)
    else $error("Outputs driven while deselected.");
  chk_sdo_off: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    !pins_s.prog |=> !O_TEST_SERIAL_OUT_OE)
    else $error("Serial output driven outside program mode.");
  chk_sdo_on: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    prog |=> O_TEST_SERIAL_OUT_OE)
    else $error("Serial output not driven in program mode.");
  chk_io_mode: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    !pins_s.prog |=> !O_TEST_SERIAL_IO_OE)
    else $error("Data line driven outside program mode.");
  chk_io_command: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    $rose(O_TEST_SERIAL_IO_OE) |-> $past(state_q) == ST_STREAM)
    else $error("Data line driven without a stream command.");
  chk_io_hold: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    s_deselect |=> hold_q ##1 (!O_TEST_SERIAL_IO_OE || $past(start_rise, 2)))
    else $error("Data line not held after deselect.");
  chk_result_latch: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    s_done |=> O_RESULT == $past(I_RESULT) && O_CONV_DONE_STROBE)
    else $error("Result not latched at conversion end.");
  chk_strobe_high: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    s_done |=> O_CONV_DONE_STROBE [*5])
    else $error("Conversion strobe ended early.");
  chk_strobe_width: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    s_done ##1 (!(I_CONV_DONE && sel)) [*5] |=> !O_CONV_DONE_STROBE)
    else $error("Conversion strobe has the wrong width.");
  chk_start_gate: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    !sel |=> !O_CONV_START_REQ)
    else $error("Start passed while deselected.");
  chk_enable_edge: assert property (@(posedge I_MCLK) disable iff (!I_RESETN || !I_MCE)
    state_q == ST_IDLE && prog && rst_rise |=> state_q == ST_LISTEN)
    else $error("Reset edge did not enable commands.");

endmodule
`default_nettype wire

/* test/sats_host_model.sv */
// Behavioural test system: oscillator clock, reset edge and serial commands.
// Assumes the bench resolves the shared data line with its pull-down.
`timescale 1ns/1ns
`default_nettype none
module sats_host_model (
  input wire logic i_clk,
  output var logic o_osc,
  output var logic o_rst,
  output var logic o_io,
  output var logic o_io_oe
);
  // ****
  // Test system
  // ****
  initial begin
    o_osc = 1'b0;
    o_rst = 1'b0;
    o_io = 1'b0;
    o_io_oe = 1'b0;
  end

  // Half of a 160 ns oscillator period; the clock stands still between frames.
  task automatic half(input logic lvl);
    repeat (8) @(posedge i_clk);
    #1 o_osc = lvl;
  endtask

  task automatic osc_cycle();
    half(1'b1);
    half(1'b0);
  endtask

  // A low-to-high edge on the reset pin opens command reception.
  task automatic enable_cmds();
    repeat (4) @(posedge i_clk);
    #1 o_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    #1 o_rst = 1'b1;
  endtask

  // Four bits, most significant first, set up while the clock is low.
  task automatic send_cmd(input logic [3:0] code);
    for (int i = 3; i >= 0; i--) begin
      o_io_oe = 1'b1;
      o_io = code[i];
      osc_cycle();
    end
    o_io_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/sats_top_tb.sv */
// Self-checking bench for the select logic and serial test port.
// Assumes sats_top and the test system model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module sats_top_tb;
  // ****
  // Bench
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_a = 1'b0;
  logic sel_b = 1'b0;
  logic prog = 1'b0;
  logic start = 1'b0;
  logic done = 1'b0;
  logic [11:0] result = 12'h000;
  logic osc, rst_pin, h_io, h_oe, io_o, io_oe, sout, sout_oe, res_oe, strb, strb_oe, sreq;
  logic cmd_v;
  logic [3:0] code;
  logic [11:0] res_q;
  int error_cnt = 0;
  int samples_checked = 0;
  int cmd_cnt = 0;
  int strb_cnt = 0;
  localparam logic [7:0] rom_addr = 8'h24;
  localparam logic [15:0] rom_data = 16'h00c3;
  localparam logic [15:0] dsp_res = 16'h0042;
  wire io_line = io_oe ? io_o : (h_oe ? h_io : 1'b0);

  initial begin
    forever #5 clk = ~clk;
  end

  sats_host_model host_u (.i_clk(clk), .o_osc(osc), .o_rst(rst_pin), .o_io(h_io),
    .o_io_oe(h_oe));

  sats_top dut_u (.I_MCLK(clk), .I_RESETN(rst_n), .I_MCE(1'b1), .I_SELECT_IN_A(sel_a),
    .I_SELECT_IN_B(sel_b), .I_PROGRAM_MODE_PIN(prog), .I_RESET_PIN(rst_pin),
    .I_CONV_START(start), .I_OSC_IN_PIN(osc), .I_TEST_SERIAL_IO_I(io_line),
    .I_DSP_ROM_ADDR(rom_addr), .I_DSP_INSTR_DATA(rom_data), .I_DSP_RESULT(dsp_res),
    .I_RESULT(result), .I_CONV_DONE(done), .O_TEST_SERIAL_IO_O(io_o),
    .O_TEST_SERIAL_IO_OE(io_oe), .O_TEST_SERIAL_OUT(sout), .O_TEST_SERIAL_OUT_OE(sout_oe),
    .O_RESULT(res_q), .O_RESULT_OE(res_oe), .O_CONV_DONE_STROBE(strb),
    .O_CONV_DONE_OE(strb_oe), .O_CONV_START_REQ(sreq), .O_CMD_VALID(cmd_v),
    .O_CMD_CODE(code));

  always @(posedge clk) begin
    if (cmd_v === 1'b1) begin
      cmd_cnt++;
    end
    if (strb === 1'b1) begin
      strb_cnt++;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Output enables follow the two selects only together.
  task automatic t_select();
    prog = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {sel_a, sel_b} = i[1:0];
      cyc(6);
      check("result oe", {15'h0, res_oe}, {15'h0, i == 3});
      check("done oe", {15'h0, strb_oe}, {15'h0, i == 3});
      check("sout oe", {15'h0, sout_oe}, {15'h0, i == 3});
      check("io oe", {15'h0, io_oe}, 16'h0);
    end
    start = 1'b1;
    cyc(6);
    check("start req", {15'h0, sreq}, 16'h1);
    $display("test select done");
  endtask

  // Command codes 3, 8 and A; only 8 and A turn the data line round.
  task automatic t_cmds();
    logic [3:0] codes [3] = '{4'h3, 4'h8, 4'ha};
    int n;
    logic exp_bit;
    foreach (codes[k]) begin
      n = cmd_cnt;
      host_u.enable_cmds();
      host_u.send_cmd(codes[k]);
      cyc(6);
      check("cmd count", 16'(cmd_cnt), 16'(n + 1));
      check("cmd code", {12'h0, code}, {12'h0, codes[k]});
      check("io oe", {15'h0, io_oe}, {15'h0, codes[k] != 4'h3});
      if (codes[k] != 4'h3) begin
        host_u.osc_cycle();
        host_u.osc_cycle();
        cyc(4);
        // The third fall of a stream shows word bit 21, which is address bit 5.
        check("io data", {15'h0, io_o}, {15'h0, rom_addr[5]});
        // Result falls so far number ten after code 8 and sixteen after code A.
        exp_bit = (codes[k] == 4'h8) ? dsp_res[6] : dsp_res[0];
        check("sout data", {15'h0, sout}, {15'h0, exp_bit});
      end
    end
    $display("test cmds done");
  endtask

  // After a deselect the data line waits for a new conversion start.
  task automatic t_hold();
    start = 1'b0;
    sel_b = 1'b0;
    cyc(6);
    check("io oe desel", {15'h0, io_oe}, 16'h0);
    sel_b = 1'b1;
    cyc(6);
    host_u.enable_cmds();
    host_u.send_cmd(4'h8);
    cyc(6);
    check("cmd code held", {12'h0, code}, 16'h0008);
    check("io oe held", {15'h0, io_oe}, 16'h0);
    start = 1'b1;
    cyc(6);
    check("io oe start", {15'h0, io_oe}, 16'h1);
    $display("test hold done");
  endtask

  // Outside program mode the test port floats and ignores commands.
  task automatic t_prog_off();
    int n;
    prog = 1'b0;
    cyc(6);
    check("sout oe off", {15'h0, sout_oe}, 16'h0);
    check("io oe off", {15'h0, io_oe}, 16'h0);
    n = cmd_cnt;
    host_u.enable_cmds();
    host_u.send_cmd(4'h8);
    cyc(6);
    check("cmd ignored", 16'(cmd_cnt), 16'(n));
    prog = 1'b1;
    $display("test prog off done");
  endtask

  // Conversion end: word latched, strobe width; refused when deselected.
  task automatic t_conv();
    result = 12'h801;
    strb_cnt = 0;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(3);
    check("result", {4'h0, res_q}, 16'h0801);
    cyc(8);
    check("strobe cycles", 16'(strb_cnt), 16'd5);
    sel_a = 1'b0;
    cyc(6);
    strb_cnt = 0;
    result = 12'h123;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(8);
    check("strobe desel", 16'(strb_cnt), 16'h0);
    check("result oe desel", {15'h0, res_oe}, 16'h0);
    check("result held", {4'h0, res_q}, 16'h0801);
    $display("test conv done");
  endtask

  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    t_select();
    t_cmds();
    t_hold();
    t_prog_off();
    t_conv();
    end_of_test();
  end

  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
